// ---- src/spo_pkg.sv ----
package spo_pkg;
  // Register byte addresses
  localparam logic [7:0]  A_CTRL       = 8'h00;
  localparam logic [7:0]  A_RAMP       = 8'h04;
  localparam logic [7:0]  A_LEVEL      = 8'h08;
  localparam logic [7:0]  A_STAT       = 8'h0c;
  localparam logic [7:0]  A_SPEED      = 8'h10;
  localparam logic [7:0]  A_USAGE      = 8'h14;
  localparam logic [7:0]  A_HIDX       = 8'h18;
  localparam logic [7:0]  A_HDATA      = 8'h1c;
  localparam logic [7:0]  A_VIEW       = 8'h20;
  localparam logic [7:0]  A_ISTAT      = 8'h24;
  localparam logic [7:0]  A_IMASK      = 8'h28;

  // CTRL layout: [2:0] layout, 3 air, 4 weight, 5 warn sync, 6 ramp, 7 level, [9:8] err mode
  typedef struct packed {
    logic [1:0] err_mode;
    logic       reach_en;
    logic       ramp_en;
    logic       warn_sync;
    logic       weight_hi;
    logic       air_det;
    logic [2:0] layout;
  } spo_ctrl_t;

  localparam int          CTRL_W       = 10;
  localparam logic [9:0]  CTRL_RST     = 10'h000;
  localparam logic [15:0] RAMP_RST     = 16'h0100;
  localparam int          LVL_PCT_LSB  = 0;
  localparam int          LVL_CNT_LSB  = 8;
  localparam logic [6:0]  PCT_RST      = 7'd90;
  localparam logic [2:0]  LMCNT_RST    = 3'd4;
  localparam logic [1:0]  ERR_OFF      = 2'd0;
  localparam logic [1:0]  ERR_ON       = 2'd1;
  localparam logic [1:0]  ERR_CODE     = 2'd2;
  localparam logic [2:0]  LAYOUT_NUM   = 3'd5;
  localparam logic [2:0]  LAYOUT_LEGACY = 3'd4;
  localparam logic [16:0] RPM_STEP_LO  = 17'd200;
  localparam logic [16:0] RPM_STEP_HI  = 17'd1000;
  localparam logic [16:0] RPM_MAX      = 17'd80000;
  localparam logic [16:0] RAMP_STEP    = 17'd100;
  localparam logic [6:0]  REACH_DEF    = 7'd90;
  localparam logic [6:0]  REACH_MIN    = 7'd50;
  localparam logic [6:0]  REACH_MAX    = 7'd100;
  localparam logic [2:0]  OVERLOAD_SEG = 3'd4;
  localparam int          HIST_DEPTH   = 10;
  localparam logic [3:0]  HIST_LAST    = 4'd9;
  localparam logic [2:0]  VIEW_LAST    = 3'd4;
  localparam int          IRQ_W        = 3;

  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned USAGE_TICK_S   = 1;
  localparam int unsigned USAGE_TICK_CYC = USAGE_TICK_S * CLK_HZ;
  localparam int unsigned CODE_SLOT_MS   = 10;
  localparam int unsigned CODE_SLOT_CYC  = CODE_SLOT_MS * (CLK_HZ / 1000);
  localparam logic [2:0]  CODE_START_LAST = 3'd3;
  localparam logic [2:0]  CODE_BITS_LAST  = 3'd7;
  localparam logic [2:0]  CODE_GAP_LAST   = 3'd3;

  typedef enum logic [1:0] {
    CG_IDLE  = 2'b00,
    CG_START = 2'b01,
    CG_BITS  = 2'b11,
    CG_GAP   = 2'b10
  } spo_cg_state_t;
endpackage : spo_pkg

// ---- src/spo_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module spo_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : spo_sync
`default_nettype wire

// ---- src/spo_code_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module spo_code_gen #(
  parameter int unsigned SLOT_CYC = spo_pkg::CODE_SLOT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       active,
  input  wire logic [7:0] code,
  output logic            pin
);
  import spo_pkg::*;

  // Frame: 4 high slots, 8 code slots MSB first, 4 low slots
  spo_cg_state_t state;
  logic [31:0]   cyc;
  logic [2:0]    slot;
  logic [7:0]    shreg;
  logic          slot_end;

  assign slot_end = (cyc == SLOT_CYC - 1);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cyc <= '0;
    end else if (state == CG_IDLE || slot_end) begin
      cyc <= '0;
    end else begin
      cyc <= cyc + 32'd1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= CG_IDLE;
      slot  <= '0;
      shreg <= '0;
    end else begin
      unique case (state)
        CG_IDLE: if (active) begin
          state <= CG_START;
          slot  <= '0;
          shreg <= code;
        end
        CG_START: if (slot_end) begin
          slot <= (slot == CODE_START_LAST) ? 3'd0 : slot + 3'd1;
          if (slot == CODE_START_LAST) state <= CG_BITS;
        end
        CG_BITS: if (slot_end) begin
          shreg <= {shreg[6:0], 1'b0};
          slot  <= (slot == CODE_BITS_LAST) ? 3'd0 : slot + 3'd1;
          if (slot == CODE_BITS_LAST) state <= CG_GAP;
        end
        CG_GAP: if (slot_end) begin
          slot <= (slot == CODE_GAP_LAST) ? 3'd0 : slot + 3'd1;
          if (slot == CODE_GAP_LAST) begin
            state <= active ? CG_START : CG_IDLE;
            shreg <= code;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin <= 1'b0;
    end else begin
      pin <= (state == CG_START) || (state == CG_BITS && shreg[7]);
    end
  end
endmodule : spo_code_gen
`default_nettype wire

// ---- src/spo_top.sv ----
// Functional notes
// - Connector layout selects one of five compatibility maps; native layout after reset.
// - In the legacy layout, cooling-air detection is switchable; off by default.
// - Each count pulse moves commanded speed 200 rpm, or 1000 rpm when weighted.
// - Warning pin shows plain warning or follows configured load-meter segment count.
// - With ramp enabled, speed target slews full scale in the configured time.
// - Speed-reached output asserts at 90 percent of commanded speed by default.
// - With level enabled, threshold is user set between 50 and 100 percent.
// - Last ten error codes are kept and readable without any setting.
// - Total motor running time is accumulated and readable.
// - A view register walks through control, ramp, level, usage time and history count one by one, read only.
// - Presets and history are handed to non-volatile storage on every change.
// - Error pin opens on error with setting off, closes with setting on.
// - In patterned mode the active error code is sent on the error pin.
// - In patterned mode the active warning code is sent on the warning pin.
// - In patterned mode both pins stay open with no error or warning.
// - Four or more lit load segments means overload and raises the warning.
`timescale 1ns/100ps
`default_nettype none
module spo_top #(
  parameter int unsigned USAGE_CYC = spo_pkg::USAGE_TICK_CYC,
  parameter int unsigned SLOT_CYC  = spo_pkg::CODE_SLOT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cnt_in,
  input  wire logic        ud_in,
  input  wire logic [16:0] actual_rpm,
  input  wire logic [2:0]  load_segments,
  input  wire logic        err_active,
  input  wire logic [7:0]  err_code,
  input  wire logic [7:0]  warn_code,
  output logic      [16:0] speed_target,
  output logic             speed_reached_out,
  output logic             err_out,
  output logic             warn_out,
  output logic      [2:0]  pin_layout,
  output logic             air_detect_en,
  output logic             nv_save,
  output logic             irq
);
  import spo_pkg::*;

  spo_ctrl_t        ctrl;
  logic [15:0]      ramp_div;
  logic [15:0]      ramp_cnt;
  logic [6:0]       reach_pct;
  logic [2:0]       lm_count;
  logic [16:0]      cmd_rpm;
  logic [1:0]       pins_s;
  logic             cnt_d;
  logic             cnt_rise;
  logic [16:0]      step;
  logic             overload;
  logic             overload_d;
  logic             err_d;
  logic             err_rise;
  logic             reach_d;
  logic [7:0]       hist [HIST_DEPTH];
  logic [3:0]       hist_cnt;
  logic [3:0]       hist_idx;
  logic [31:0]      usage_cyc;
  logic [31:0]      usage_sec;
  logic [2:0]       view_idx;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] imask;
  logic [IRQ_W-1:0] events;
  logic             err_pat;
  logic             warn_pat;
  logic             setup;
  logic             wr;
  logic             rd;
  logic [6:0]       eff_pct;
  logic [23:0]      act_x;
  logic [23:0]      cmd_x;
  logic [23:0]      view_val;
  logic [31:0]      next_prdata;
  logic             next_slverr;
  logic [6:0]       wr_pct;

  spo_sync #(.W(2)) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    ({ud_in, cnt_in}),
    .dout   (pins_s)
  );

  spo_code_gen #(.SLOT_CYC(SLOT_CYC)) u_err_code (
    .mclk   (mclk),
    .resetn (resetn),
    .active (ctrl.err_mode == ERR_CODE && err_active),
    .code   (err_code),
    .pin    (err_pat)
  );

  spo_code_gen #(.SLOT_CYC(SLOT_CYC)) u_warn_code (
    .mclk   (mclk),
    .resetn (resetn),
    .active (ctrl.err_mode == ERR_CODE && overload),
    .code   (warn_code),
    .pin    (warn_pat)
  );

  // APB: pready is raised from the setup cycle, so every access takes one wait-free cycle
  assign setup    = psel && !penable;
  assign wr       = psel && penable && pready && pwrite;
  assign rd       = psel && penable && pready && !pwrite;
  assign cnt_rise = pins_s[0] && !cnt_d;
  assign step     = ctrl.weight_hi ? RPM_STEP_HI : RPM_STEP_LO;
  assign overload = (load_segments >= OVERLOAD_SEG);
  assign err_rise = err_active && !err_d;
  assign wr_pct   = pwdata[LVL_PCT_LSB +: 7];

  always_comb begin
    eff_pct = REACH_DEF;
    if (ctrl.reach_en) eff_pct = reach_pct;
    act_x = 24'(actual_rpm) * 24'(REACH_MAX);
    cmd_x = 24'(cmd_rpm) * 24'(eff_pct);
  end

  always_comb begin
    unique case (view_idx)
      3'd0:    view_val = 24'(ctrl);
      3'd1:    view_val = 24'(ramp_div);
      3'd2:    view_val = {13'h0, lm_count, 1'b0, reach_pct};
      3'd3:    view_val = usage_sec[23:0];
      3'd4:    view_val = 24'(hist_cnt);
      default: view_val = 24'h000000;
    endcase
  end

  always_comb begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    unique case (paddr)
      A_CTRL:  next_prdata = 32'(ctrl);
      A_RAMP:  next_prdata = 32'(ramp_div);
      A_LEVEL: next_prdata = {21'h0, lm_count, 1'b0, reach_pct};
      A_STAT:  next_prdata = {7'h00, speed_target, hist_cnt, warn_out, err_out,
                              overload, speed_reached_out};
      A_SPEED: next_prdata = 32'(cmd_rpm);
      A_USAGE: next_prdata = usage_sec;
      A_HIDX:  next_prdata = 32'(hist_idx);
      A_HDATA: next_prdata = 32'(hist[hist_idx]);
      A_VIEW:  next_prdata = {5'h00, view_idx, view_val};
      A_ISTAT: next_prdata = 32'(istat);
      A_IMASK: next_prdata = 32'(imask);
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= next_prdata;
        pslverr <= next_slverr;
      end
    end
  end

  // Configuration registers; an out-of-range layout write leaves the layout alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= CTRL_RST;
      ramp_div  <= RAMP_RST;
      reach_pct <= PCT_RST;
      lm_count  <= LMCNT_RST;
      hist_idx  <= '0;
      imask     <= '0;
    end else if (wr) begin
      unique case (paddr)
        A_CTRL: begin
          ctrl <= pwdata[CTRL_W-1:0];
          if (pwdata[2:0] >= LAYOUT_NUM) ctrl.layout <= ctrl.layout;
        end
        A_RAMP: ramp_div <= pwdata[15:0];
        A_LEVEL: begin
          lm_count  <= pwdata[LVL_CNT_LSB +: 3];
          reach_pct <= (wr_pct < REACH_MIN) ? REACH_MIN :
                       (wr_pct > REACH_MAX) ? REACH_MAX : wr_pct;
        end
        A_HIDX: hist_idx <= (pwdata[3:0] > HIST_LAST) ? HIST_LAST : pwdata[3:0];
        A_IMASK: imask <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // View walks the settings on each read and never alters them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      view_idx <= '0;
    end else if (rd && paddr == A_VIEW) begin
      view_idx <= (view_idx == VIEW_LAST) ? 3'd0 : view_idx + 3'd1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_layout    <= '0;
      air_detect_en <= 1'b1;
    end else begin
      pin_layout    <= ctrl.layout;
      air_detect_en <= (ctrl.layout == LAYOUT_LEGACY) ? ctrl.air_det : 1'b1;
    end
  end

  // Commanded speed from count pulses, saturating at both ends
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_d   <= 1'b0;
      cmd_rpm <= '0;
    end else begin
      cnt_d <= pins_s[0];
      if (cnt_rise) begin
        if (pins_s[1]) begin
          cmd_rpm <= (cmd_rpm > RPM_MAX - step) ? RPM_MAX : cmd_rpm + step;
        end else begin
          cmd_rpm <= (cmd_rpm < step) ? 17'd0 : cmd_rpm - step;
        end
      end
    end
  end

  // Ramp moves one step per ramp_div+1 cycles, so full scale takes 800 steps
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ramp_cnt     <= '0;
      speed_target <= '0;
    end else if (!ctrl.ramp_en) begin
      ramp_cnt     <= '0;
      speed_target <= cmd_rpm;
    end else if (ramp_cnt >= ramp_div) begin
      ramp_cnt <= '0;
      if (speed_target + RAMP_STEP <= cmd_rpm) begin
        speed_target <= speed_target + RAMP_STEP;
      end else if (speed_target >= cmd_rpm + RAMP_STEP) begin
        speed_target <= speed_target - RAMP_STEP;
      end else begin
        speed_target <= cmd_rpm;
      end
    end else begin
      ramp_cnt <= ramp_cnt + 16'd1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      speed_reached_out <= 1'b0;
    end else begin
      speed_reached_out <= (cmd_rpm != 17'd0) && (act_x >= cmd_x);
    end
  end

  // Pin level 1 means contact closed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      err_out  <= 1'b0;
      warn_out <= 1'b0;
    end else begin
      unique case (ctrl.err_mode)
        ERR_ON:   err_out <= err_active;
        ERR_CODE: err_out <= err_active && err_pat;
        default:  err_out <= !err_active;
      endcase
      if (ctrl.err_mode == ERR_CODE) begin
        warn_out <= overload && warn_pat;
      end else if (ctrl.warn_sync) begin
        warn_out <= (load_segments >= lm_count);
      end else begin
        warn_out <= overload;
      end
    end
  end

  // Newest error code lands in slot 0
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      err_d    <= 1'b0;
      hist_cnt <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) hist[i] <= '0;
    end else begin
      err_d <= err_active;
      if (err_rise) begin
        hist[0] <= err_code;
        for (int i = 1; i < HIST_DEPTH; i++) hist[i] <= hist[i-1];
        if (hist_cnt != 4'(HIST_DEPTH)) hist_cnt <= hist_cnt + 4'd1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      usage_cyc <= '0;
      usage_sec <= '0;
    end else if (actual_rpm != 17'd0) begin
      if (usage_cyc == USAGE_CYC - 1) begin
        usage_cyc <= '0;
        usage_sec <= usage_sec + 32'd1;
      end else begin
        usage_cyc <= usage_cyc + 32'd1;
      end
    end
  end

  // Storage hand-off; an external controller writes the snapshot away
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      nv_save <= 1'b0;
    end else begin
      nv_save <= err_rise || (wr && (paddr == A_CTRL || paddr == A_RAMP ||
                                     paddr == A_LEVEL));
    end
  end

  // Events: error onset, overload onset, speed reached; set beats a same-cycle clear
  assign events = {speed_reached_out && !reach_d, overload && !overload_d, err_rise};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reach_d    <= 1'b0;
      overload_d <= 1'b0;
      istat      <= '0;
      irq        <= 1'b0;
    end else begin
      reach_d    <= speed_reached_out;
      overload_d <= overload;
      istat      <= (istat & ~((wr && paddr == A_ISTAT) ? pwdata[IRQ_W-1:0] : '0)) | events;
      irq        <= |(istat & imask);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_up_pulse(logic [16:0] st, logic hi);
    cnt_rise && pins_s[1] && ctrl.weight_hi == hi && step == st && cmd_rpm <= RPM_MAX - st;
  endsequence

  a_pulse_light: assert property (s_up_pulse(RPM_STEP_LO, 1'b0) |=>
    cmd_rpm == $past(cmd_rpm) + 17'd200) else $error("light pulse step wrong");
  a_pulse_heavy: assert property (s_up_pulse(RPM_STEP_HI, 1'b1) |=>
    cmd_rpm == $past(cmd_rpm) + 17'd1000) else $error("heavy pulse step wrong");
  a_err_open: assert property (ctrl.err_mode == ERR_OFF && err_active |=> !err_out)
    else $error("error pin not open on error");
  a_err_closed: assert property (ctrl.err_mode == ERR_ON && err_active |=> err_out)
    else $error("error pin not closed on error");
  a_code_quiet: assert property (ctrl.err_mode == ERR_CODE && !err_active && !overload
    |=> !err_out && !warn_out) else $error("patterned pins not open when idle");
  a_overload_warn: assert property (ctrl.err_mode != ERR_CODE && !ctrl.warn_sync
    && load_segments >= 3'd4 |=> warn_out) else $error("overload not warned");
  a_reach_def: assert property (!ctrl.reach_en && cmd_rpm != 0 &&
    24'(actual_rpm) * 24'd10 >= 24'(cmd_rpm) * 24'd9 |=> speed_reached_out)
    else $error("speed reached missing at 90 percent");
  a_hist_push: assert property (err_rise |=> hist[0] == $past(err_code))
    else $error("error history not updated");
  a_ramp_bypass: assert property (!ctrl.ramp_en ##1 !ctrl.ramp_en |->
    speed_target == $past(cmd_rpm)) else $error("target not following command");
  a_ramp_slew: assert property (ctrl.ramp_en |=>
    (speed_target - $past(speed_target) <= RAMP_STEP) ||
    ($past(speed_target) - speed_target <= RAMP_STEP)) else $error("ramp step too big");
  a_layout_keep: assert property (wr && paddr == A_CTRL && pwdata[2:0] > 3'd4
    |=> ctrl.layout == $past(ctrl.layout)) else $error("bad layout accepted");
  a_irq_level: assert property ((istat & imask) != 0 |=> irq)
    else $error("interrupt not raised");
endmodule : spo_top
`default_nettype wire

// ---- dv/spo_mc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Machine controller side: it only watches the contacts and counts closures
module spo_mc_model (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic err_out,
  input  wire logic warn_out,
  output var int    err_rise,
  output var int    warn_rise
);
  logic err_prev;
  logic warn_prev;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      err_prev  <= 1'b0;
      warn_prev <= 1'b0;
      err_rise  <= 0;
      warn_rise <= 0;
    end else begin
      err_prev  <= err_out;
      warn_prev <= warn_out;
      // A closure is counted once per open to closed transition
      if (err_out === 1'b1 && err_prev === 1'b0) err_rise <= err_rise + 1;
      if (warn_out === 1'b1 && warn_prev === 1'b0) warn_rise <= warn_rise + 1;
    end
  end
endmodule : spo_mc_model
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import spo_pkg::*;
  logic        mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        cnt_in = 0, ud_in = 1, err_active = 0, slv;
  logic [7:0]  paddr = 0, err_code = 0, warn_code = 0;
  logic [31:0] pwdata = 0, rd, rng = 70, u0;
  logic [16:0] actual_rpm = 0, cmd = 0;
  logic [2:0]  load_segments = 0;
  logic [31:0] prdata;
  logic [16:0] speed_target;
  logic [2:0]  pin_layout;
  logic        pready, pslverr, speed_reached_out, err_out, warn_out;
  logic        air_detect_en, nv_save, irq;
  spo_ctrl_t   c;
  int          err_count = 0, n_compared = 0, cyc = 0, nv_cnt = 0, err_rise, warn_rise, e0;

  spo_top #(.USAGE_CYC(8), .SLOT_CYC(4)) dut (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cnt_in(cnt_in), .ud_in(ud_in),
    .actual_rpm(actual_rpm), .load_segments(load_segments), .err_active(err_active),
    .err_code(err_code), .warn_code(warn_code), .speed_target(speed_target),
    .speed_reached_out(speed_reached_out), .err_out(err_out), .warn_out(warn_out),
    .pin_layout(pin_layout), .air_detect_en(air_detect_en), .nv_save(nv_save), .irq(irq));
  spo_mc_model mc (.mclk(mclk), .resetn(resetn), .err_out(err_out), .warn_out(warn_out),
    .err_rise(err_rise), .warn_rise(warn_rise));

  initial begin
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (nv_save === 1'b1) nv_cnt++;
    // Whole run needs under a thousand cycles; a hang is cut well beyond that
    if (cyc >= 20000) begin
      err_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  function automatic logic [16:0] nxt(input logic [16:0] s, input logic up, input logic w);
    int r;
    r = up ? s + (w ? RPM_STEP_HI : RPM_STEP_LO) : s - (w ? RPM_STEP_HI : RPM_STEP_LO);
    if (r < 0) r = 0;
    if (r > int'(RPM_MAX)) r = RPM_MAX;
    return r[16:0];
  endfunction : nxt

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No local limit: only the bench timeout may end a stalled access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_ctrl();
    apb(1, A_CTRL, {22'h0, c});
    // Pin outputs register the new settings one edge after the write lands
    repeat (2) @(posedge mclk);
  endtask : wr_ctrl

  task automatic pulse(input logic up);
    @(posedge mclk);
    ud_in <= up;
    cnt_in <= 1'b1;
    repeat (3) @(posedge mclk);
    cnt_in <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : pulse

  // Drive the threshold value and one rpm below it; only the former counts as reached
  task automatic reach(input int pct);
    int b;
    b = (cmd * pct + 99) / 100;
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk);
      actual_rpm <= 17'(b - j);
      repeat (4) @(posedge mclk);
      chk(speed_reached_out, ((b - j) * 100 >= cmd * pct), "reached level");
    end
  endtask : reach

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    apb(0, A_CTRL, 0); chk(rd, 0, "ctrl reset");
    chk(pin_layout, 0, "native layout");
    apb(0, A_RAMP, 0); chk(rd, 32'h100, "ramp reset");
    apb(0, A_LEVEL, 0); chk(rd, 32'h45a, "level reset");
    for (int i = 0; i < 6; i++) begin
      c = '0;
      c.layout = 3'(i);
      wr_ctrl();
      chk(pin_layout, (i < 5) ? i : 4, "layout select");
    end
    c = '0; c.layout = LAYOUT_LEGACY; c.air_det = 1'b1; wr_ctrl();
    chk(air_detect_en, 1, "air on");
    c.air_det = 1'b0; wr_ctrl();
    chk(air_detect_en, 0, "air off");
    chk(nv_cnt > 0, 1, "nv save pulse");
    for (int w = 0; w < 2; w++) begin
      c = '0; c.weight_hi = w[0]; wr_ctrl();
      for (int k = 0; k < 6; k++) begin
        u0[0] = (k == 0) ? 1'b0 : (k < 4) ? 1'b1 : xs() & 1;
        pulse(u0[0]);
        cmd = nxt(cmd, u0[0], w[0]);
        apb(0, A_SPEED, 0); chk(rd, cmd, "count step");
      end
      chk(speed_target, cmd, "target follows");
    end
    c = '0; wr_ctrl();
    reach(90);
    c.reach_en = 1'b1; wr_ctrl();
    u0 = 50 + xs() % 51;
    apb(1, A_LEVEL, 32'h400 | u0);
    reach(u0);
    apb(1, A_LEVEL, 32'h400 | 30); apb(0, A_LEVEL, 0); chk(rd[6:0], 50, "pct clamp");
    c = '0; c.ramp_en = 1'b1; c.weight_hi = 1'b1; wr_ctrl(); apb(1, A_RAMP, 3);
    pulse(1); cmd = nxt(cmd, 1, 1);
    chk(speed_target == cmd, 0, "ramp slews");
    repeat (60) @(posedge mclk);
    chk(speed_target, cmd, "ramp done");
    c = '0; wr_ctrl(); apb(1, A_IMASK, 1);
    err_code <= xs(); err_active <= 1'b1; repeat (4) @(posedge mclk);
    chk(err_out, 0, "off mode opens");
    chk(irq, 1, "irq raised");
    apb(1, A_HIDX, 0); apb(0, A_HDATA, 0); chk(rd[7:0], err_code, "history");
    apb(1, A_ISTAT, 1); apb(0, A_ISTAT, 0); chk(rd[0], 0, "istat clear");
    chk(irq, 0, "irq cleared");
    apb(1, A_IMASK, 0); err_active <= 1'b0; repeat (3) @(posedge mclk);
    c.err_mode = ERR_ON; wr_ctrl(); err_active <= 1'b1; repeat (4) @(posedge mclk);
    chk(err_out, 1, "on mode closes");
    chk(irq, 0, "masked irq");
    err_active <= 1'b0; c.err_mode = ERR_CODE; wr_ctrl(); repeat (4) @(posedge mclk);
    chk({err_out, warn_out}, 0, "code idle open");
    err_active <= 1'b1; repeat (8) @(posedge mclk);
    chk(err_out, 1, "code start slots");
    warn_code <= xs() | 8'h01; load_segments <= 3'd5; u0 = warn_rise;
    e0 = err_rise;
    repeat (200) @(posedge mclk);
    chk(warn_rise > u0, 1, "warn pattern");
    chk(err_rise > e0, 1, "error pattern repeats");
    apb(0, A_STAT, 0); chk(rd[1], 1, "overload");
    err_active <= 1'b0; load_segments <= 3'd3; c.err_mode = ERR_OFF; wr_ctrl();
    apb(0, A_STAT, 0); chk(rd[1], 0, "no overload");
    chk(warn_out, 0, "plain warn open");
    load_segments <= OVERLOAD_SEG; repeat (3) @(posedge mclk);
    chk(warn_out, 1, "plain warn closed");
    c.warn_sync = 1'b1; wr_ctrl(); apb(1, A_LEVEL, 32'h200 | 90);
    load_segments <= 3'd2; repeat (3) @(posedge mclk);
    chk(warn_out, 1, "sync at count");
    load_segments <= 3'd1; repeat (3) @(posedge mclk);
    chk(warn_out, 0, "sync below count");
    actual_rpm <= 17'd1000; apb(0, A_USAGE, 0); u0 = rd;
    repeat (40) @(posedge mclk);
    apb(0, A_USAGE, 0); chk(rd - u0 >= 4, 1, "usage counts");
    for (int i = 0; i < 5; i++) begin
      apb(0, A_VIEW, 0); chk(rd[26:24], i, "view walk");
      if (i < 3) chk(rd[23:0], (i == 0) ? 32'(c) : (i == 1) ? 32'd3 : 32'h25a, "view value");
    end
    apb(0, 8'h40, 0); chk(slv, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
